/* verilog/sss_map.svh */
// constants and field layouts for the simo service sequencer
// assumes inclusion by the package and by every design file that needs a number
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH
// channel count and field widths
`define SSS_NCH 3
`define SSS_TV_W 8
`define SSS_IP_W 2
`define SSS_EN_W 3
// forced-on enable codes
`define SSS_EN_FORCE0 3'h6
`define SSS_EN_FORCE1 3'h7
// enable code that follows main bias, and the off code
`define SSS_EN_BIAS 3'h4
`define SSS_EN_OFF 3'h0
// soft start: one target code per step; 5 mV/us with 25 mV code assumed
`define SSS_SS_MV_PER_US 5
`define SSS_TV_MV_PER_CODE 25
`define SSS_CLK_MHZ 40
// least spacing of a step, rounded up in cycles
`define SSS_SS_STEP_CYC \
  ((`SSS_TV_MV_PER_CODE * `SSS_CLK_MHZ + `SSS_SS_MV_PER_US - 1) / `SSS_SS_MV_PER_US)
`define SSS_SS_CNT_W 12
`endif

/* verilog/sss_pkg.sv */
// types for the simo service sequencer
// assumes sss_map.svh alongside
`include "sss_map.svh"
package sss_pkg;
  // sequencer states, gray along rest-charge-discharge
  typedef enum logic [1:0] {
    SSS_REST = 2'b00,
    SSS_CHARGE = 2'b01,
    SSS_DISCH = 2'b11
  } sss_state_t;
  // switch drive bundle
  typedef struct packed {
    logic charge_on;
    logic [`SSS_NCH-1:0] disch_sel;
  } sss_sw_t;
endpackage

/* verilog/sss_softstart.sv */
// one channel's soft-start target ramp
// assumes a 40 MHz clock and a step enable from the top
`timescale 1ns/1ps
`include "sss_map.svh"
module sss_softstart #(
  parameter int TV_W = `SSS_TV_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic step_en,
  input wire logic on,
  input wire logic [TV_W-1:0] target,
  // ramped target
  output logic [TV_W-1:0] ramp
);
  typedef struct packed {
    logic [TV_W-1:0] ramp;
  } sss_ss_state_t;
  sss_ss_state_t st_r, st_nxt;
  // ---------------------------------------------------------------
  // ramp step
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (!on) begin
      // off restarts the ramp from zero
      st_nxt.ramp = '0;
    end else if (step_en && st_r.ramp < target) begin
      st_nxt.ramp = st_r.ramp + TV_W'(1);
    end else if (st_r.ramp > target) begin
      // downward moves need no limit
      st_nxt.ramp = target;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign ramp = st_r.ramp;
  chk_ramp_single_step: assert property (@(posedge clock) disable iff (rst)
    (on && $past(on) && st_r.ramp > $past(st_r.ramp)) |-> st_r.ramp == $past(st_r.ramp) + 1)
    else $error("ramp jumped more than one code");
endmodule

/* verilog/sss_top.sv */
// simo service sequencer: arbitration, switch sequencing, discharge control
// assumes synchronous comparator inputs and one 40 MHz clock
`timescale 1ns/1ps
`include "sss_map.svh"
module sss_top #(
  parameter int NCH = `SSS_NCH,
  parameter int TV_W = `SSS_TV_W,
  parameter int IP_W = `SSS_IP_W,
  parameter int SS_STEP = `SSS_SS_STEP_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // per-channel configuration
  input wire logic [NCH*TV_W-1:0] target_voltage_field,
  input wire logic [NCH*IP_W-1:0] peak_current_limit_field,
  input wire logic [NCH*`SSS_EN_W-1:0] channel_enable_field,
  input wire logic [NCH-1:0] discharge_enable_bit,
  input wire logic [NCH-1:0] discharge_default,
  // supply status
  input wire logic main_bias_on,
  input wire logic sys_in_uvlo_window,
  // analog comparators
  input wire logic [NCH-1:0] out_low,
  input wire logic peak_reached,
  input wire logic zero_current_indication,
  // switch drives and analog settings
  output logic charge_on,
  output logic [NCH-1:0] disch_sel,
  output logic [NCH-1:0] discharge_resistor,
  output logic [IP_W-1:0] peak_limit_sel,
  output logic [NCH*TV_W-1:0] ramp_target,
  output logic [NCH-1:0] channel_on,
  output logic busy
);
  typedef struct packed {
    sss_pkg::sss_state_t st;
    sss_pkg::sss_sw_t sw;
    logic [NCH-1:0] cur;
    logic [NCH-1:0] last;
    logic [IP_W-1:0] ip;
    logic [NCH-1:0] dres;
    logic [NCH-1:0] on;
    logic [`SSS_SS_CNT_W-1:0] ss_cnt;
    logic ss_step;
    // registered so the busy output needs no decode after the flops
    logic busy;
  } sss_top_state_t;
  sss_top_state_t st_r, st_nxt;
  // ramp values of the softstart instances
  logic [NCH*TV_W-1:0] ramp_w;
  // combinational helpers
  logic [NCH-1:0] req;
  logic [NCH-1:0] grant;
  logic [NCH-1:0] on_c;
  logic [NCH-1:0] forced;
  logic [`SSS_EN_W-1:0] en_code;
  int idx;

  // ---------------------------------------------------------------
  // per-channel soft start
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++) begin : g_ss
    sss_softstart #(.TV_W(TV_W)) u_ss (
      .clock(clock),
      .rst(rst),
      .step_en(st_r.ss_step),
      .on(st_r.on[g]),
      .target(target_voltage_field[g*TV_W +: TV_W]),
      .ramp(ramp_w[g*TV_W +: TV_W])
    );
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    forced = '0;
    on_c = '0;
    req = '0;
    grant = '0;
    en_code = '0;
    idx = 0;
    // soft-start step divider
    if (st_r.ss_cnt >= `SSS_SS_CNT_W'(SS_STEP - 1)) begin
      st_nxt.ss_cnt = '0;
      st_nxt.ss_step = 1'b1;
    end else begin
      st_nxt.ss_cnt = st_r.ss_cnt + `SSS_SS_CNT_W'(1);
      st_nxt.ss_step = 1'b0;
    end
    for (int c = 0; c < NCH; c++) begin
      en_code = channel_enable_field[c*`SSS_EN_W +: `SSS_EN_W];
      forced[c] = (en_code == `SSS_EN_FORCE0) || (en_code == `SSS_EN_FORCE1);
      on_c[c] = forced[c] || ((en_code == `SSS_EN_BIAS) && main_bias_on);
      // discharge when off if enabled, or in the uvlo window by default; never when forced, per channel
      st_nxt.dres[c] = (discharge_enable_bit[c] && !on_c[c] && !forced[c])
        || (discharge_default[c] && sys_in_uvlo_window && !forced[c]);
    end
    st_nxt.on = on_c;
    // low output requests, skip idle channels
    req = out_low & st_r.on;
    for (int k = NCH; k >= 1; k--) begin
      idx = 0;
      for (int c = 0; c < NCH; c++) begin
        if (st_r.last[c]) begin
          idx = (c + k) % NCH;
        end
      end
      if (req[idx]) begin
        grant = '0;
        grant[idx] = 1'b1;
      end
    end
    case (st_r.st)
      sss_pkg::SSS_REST: begin
        st_nxt.sw = '0;
        if (grant != '0) begin
          st_nxt.st = sss_pkg::SSS_CHARGE;
          st_nxt.cur = grant;
          st_nxt.sw.charge_on = 1'b1;
          for (int c = 0; c < NCH; c++) begin
            if (grant[c]) begin
              st_nxt.ip = peak_current_limit_field[c*IP_W +: IP_W];
            end
          end
        end
      end
      sss_pkg::SSS_CHARGE: begin
        if (peak_reached) begin
          st_nxt.st = sss_pkg::SSS_DISCH;
          st_nxt.sw.charge_on = 1'b0;
          st_nxt.sw.disch_sel = st_r.cur;
        end
      end
      sss_pkg::SSS_DISCH: begin
        if (zero_current_indication) begin
          st_nxt.st = sss_pkg::SSS_REST;
          st_nxt.sw = '0;
          st_nxt.last = st_r.cur;
        end
      end
      default: begin
        st_nxt.st = sss_pkg::SSS_REST;
        st_nxt.sw = '0;
      end
    endcase
    // busy follows the next state, so it flips on the same edge as the switches
    st_nxt.busy = (st_nxt.st != sss_pkg::SSS_REST);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      // last points at top channel so channel 0 goes first
      st_r.last <= NCH'(1) << (NCH - 1);
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign charge_on = st_r.sw.charge_on;
  assign disch_sel = st_r.sw.disch_sel;
  assign discharge_resistor = st_r.dres;
  assign peak_limit_sel = st_r.ip;
  assign ramp_target = ramp_w;
  assign channel_on = st_r.on;
  assign busy = st_r.busy;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_rest_no_switch: assert property (@(posedge clock) disable iff (rst)
    (st_r.st == sss_pkg::SSS_REST) |-> !charge_on && disch_sel == '0)
    else $error("switching while resting");
  chk_charge_until_peak: assert property (@(posedge clock) disable iff (rst)
    (charge_on && !peak_reached) |=> charge_on)
    else $error("charge dropped before peak");
  chk_peak_to_disch: assert property (@(posedge clock) disable iff (rst)
    (charge_on && peak_reached) |=> !charge_on && disch_sel == $past(st_r.cur))
    else $error("no discharge after peak");
  chk_disch_hold: assert property (@(posedge clock) disable iff (rst)
    (disch_sel != '0 && !zero_current_indication) |=> disch_sel == $past(disch_sel))
    else $error("discharge ended early");
  chk_one_hot_disch: assert property (@(posedge clock) disable iff (rst)
    $onehot0(disch_sel) && !(charge_on && disch_sel != '0))
    else $error("switch conflict");
  chk_skip_idle: assert property (@(posedge clock) disable iff (rst)
    (st_r.st == sss_pkg::SSS_REST && req == '0) |=> !charge_on)
    else $error("idle channel serviced");
  chk_rr_rotate: assert property (@(posedge clock) disable iff (rst)
    (st_r.st == sss_pkg::SSS_REST && $countones(req) > 1) |-> (grant & st_r.last) == '0)
    else $error("same channel twice while others wait");
  chk_forced_no_dres: assert property (@(posedge clock) disable iff (rst)
    forced != '0 |=> (discharge_resistor & $past(forced)) == '0)
    else $error("discharge on forced channel");
  chk_dres_when_off: assert property (@(posedge clock) disable iff (rst)
    (discharge_enable_bit == '0 && !sys_in_uvlo_window) |=> discharge_resistor == '0)
    else $error("discharge without enable");
  chk_zero_ends_cycle: assert property (@(posedge clock) disable iff (rst)
    (disch_sel != '0 && zero_current_indication) |=> !busy && disch_sel == '0)
    else $error("discharge kept after zero current");
  chk_request_starts: assert property (@(posedge clock) disable iff (rst)
    (st_r.st == sss_pkg::SSS_REST && req != '0) |=> charge_on && busy)
    else $error("request left unserved at rest");
  chk_limit_applied: assert property (@(posedge clock) disable iff (rst)
    (st_r.st == sss_pkg::SSS_REST && grant[0]) |=>
      peak_limit_sel == $past(peak_current_limit_field[IP_W-1:0]))
    else $error("wrong peak limit for channel 0");
endmodule

/* tb/sss_partner.sv */
// far-side model: power switches with inductor peak and zero comparators
// assumes the sequencer's switch drives; each phase answers dly+1 cycles after its drive changes
`timescale 1ns/1ps
module sss_partner (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // switch drives and answer delay
  input wire logic charge_on,
  input wire logic [2:0] disch_sel,
  input wire logic [3:0] dly,
  // comparator outputs
  output logic peak_reached,
  output logic zero_current_indication
);
  logic [3:0] cnt_r; // cycles spent in the present phase
  logic ch_r; // charge drive one cycle ago, marks phase changes
  // restart the count on a phase change so a stale count never answers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      ch_r <= 1'b0;
    end else begin
      ch_r <= charge_on;
      if (charge_on != ch_r || !(charge_on || disch_sel != 3'h0)) cnt_r <= 4'h0;
      else if (cnt_r != dly) cnt_r <= cnt_r + 4'h1;
    end
  end
  // current ramps only while charging, decays only while discharging
  assign peak_reached = charge_on && ch_r && cnt_r == dly;
  assign zero_current_indication = !charge_on && !ch_r && disch_sel != 3'h0 && cnt_r == dly;
endmodule

/* tb/sss_top_tb_top.sv */
// testbench for the simo service sequencer
// assumes sss_top and sss_partner; inputs change on rising edges, checks on falling
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module sss_top_tb_top;
  logic clock = 0, rst = 1, bias = 0, uv = 0, peak, zero, ch_on, busy;
  logic [8:0] en = 9'h000;
  logic [2:0] low = 0, deb = 0, def = 0, dsel, res, on;
  logic [3:0] dly = 4'h1;
  logic [1:0] ipsel;
  logic [23:0] ramp;
  int n_errors = 0, checks = 0, i;
  sss_top #(.SS_STEP(2)) DUT (.clock(clock), .rst(rst),
    .target_voltage_field(24'h05_0403), .peak_current_limit_field(6'h39),
    .channel_enable_field(en), .discharge_enable_bit(deb), .discharge_default(def),
    .main_bias_on(bias), .sys_in_uvlo_window(uv), .out_low(low), .peak_reached(peak),
    .zero_current_indication(zero), .charge_on(ch_on), .disch_sel(dsel),
    .discharge_resistor(res), .peak_limit_sel(ipsel), .ramp_target(ramp),
    .channel_on(on), .busy(busy));
  sss_partner far (.clock(clock), .rst(rst), .charge_on(ch_on), .disch_sel(dsel),
    .dly(dly), .peak_reached(peak), .zero_current_indication(zero));
  // ----------------------------------------
  // clock, reset and helpers
  // ----------------------------------------
  initial forever #12.5 clock = ~clock;
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic end_of_test;
    if (n_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // one whole cycle for channel c: charge, discharge, back to rest
  // nl is the next request pattern, put on while busy so the rest cycle sees it
  task automatic serve(input int c, input logic [2:0] nl);
    for (i = 0; i < 40 && ch_on !== 1'b1; i++) cyc(1);
    `CHK({ch_on, ipsel}, {1'b1, 2'(c + 1)})
    for (i = 0; i < 40 && dsel === 3'h0; i++) cyc(1);
    `CHK({ch_on, dsel}, {1'b0, 3'(1 << c)})
    @(posedge clock) low <= nl;
    for (i = 0; i < 40 && busy !== 1'b0; i++) cyc(1);
    `CHK({busy, dsel}, 4'h0)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rest;
    cyc(6);
    `CHK({busy, ch_on, dsel}, 5'h00)
  endtask
  // ramp must climb no faster than one code per step
  task automatic t_soft;
    @(posedge clock) begin en <= 9'h124; bias <= 1'b1; end
    cyc(4);
    `CHK(ramp[7:0] <= 8'h02, 1'b1)
    cyc(30);
    `CHK(ramp, 24'h05_0403)
  endtask
  // rotation starts at channel 0, skips idle and disabled ones
  task automatic t_arb;
    @(posedge clock) low <= 3'h7;
    serve(0, 3'h7);
    serve(1, 3'h7);
    serve(2, 3'h7);
    serve(0, 3'h0);
    @(posedge clock) begin low <= 3'h5; dly <= 4'h6; end
    serve(2, 3'h5);
    serve(0, 3'h0);
    // channel_on lags the enable by a cycle, so requests come one edge later
    @(posedge clock) begin en <= 9'h104; dly <= 4'h1; end
    @(posedge clock) low <= 3'h7;
    serve(2, 3'h7);
    serve(0, 3'h7);
    serve(2, 3'h0);
    cyc(10);
    `CHK(busy, 1'b0)
  endtask
  // one discharge setting, then the switch and on state it must give
  task automatic t_dis(input logic [8:0] e, input logic b, input logic [2:0] d,
    input logic [2:0] f, input logic u, input logic [5:0] exp);
    @(posedge clock) begin en <= e; bias <= b; deb <= d; def <= f; uv <= u; end
    cyc(3);
    `CHK({res, on}, exp)
  endtask
  initial begin
    cyc(5);
    @(posedge clock) rst <= 1'b0;
    t_rest;
    t_soft;
    t_arb;
    t_dis(9'h000, 1, 3'h5, 3'h0, 0, 6'o50);
    t_dis(9'h000, 1, 3'h0, 3'h0, 0, 6'o00);
    t_dis(9'h13e, 0, 3'h7, 3'h0, 0, 6'o43);
    t_dis(9'h13e, 1, 3'h7, 3'h0, 0, 6'o07);
    t_dis(9'h000, 1, 3'h0, 3'h7, 1, 6'o70);
    t_dis(9'h006, 1, 3'h0, 3'h7, 1, 6'o61);
    end_of_test;
  end
  // watchdog at 8000 cycles: the whole sequence needs well under that
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
endmodule
